// ===== csp_consts.svh
// constants for the clocked serial port: offsets, fields, counts
// assumes inclusion by name from every design file that needs them
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH
`define CSP_OFF_IRQ_FLAG  12'h304
`define CSP_OFF_IRQ_MASK  12'h320
`define CSP_OFF_PULLUP    12'h35C
`define CSP_OFF_CONFIG    12'h36C
`define CSP_OFF_RUN       12'h370
`define CSP_OFF_DATA_LO   12'h374
`define CSP_OFF_DATA_HI   12'h378
`define CSP_IDX_IRQ_FLAG  8'hC1
`define CSP_IDX_IRQ_MASK  8'hC8
`define CSP_IDX_PULLUP    8'hD7
`define CSP_IDX_CONFIG    8'hDB
`define CSP_IDX_RUN       8'hDC
`define CSP_IDX_DATA_LO   8'hDD
`define CSP_IDX_DATA_HI   8'hDE
`define CSP_BIT_PFS       3
`define CSP_BIT_ORDER     2
`define CSP_BIT_MASK_SIO  1
`define CSP_BIT_PORT2_PULLUP_ENABLE      2
`define CSP_BIT_RUN       1
`define CSP_BIT_TRIG      0
`define CSP_BIT_FLAG      0
`define CSP_NIB_RESET     4'h0
`define CSP_BITS          4'h8
`define CSP_MODE_CLK      2'h3
`define CSP_MODE_CLK2     2'h2
`define CSP_MODE_TIMER_OVERFLOW_SIGNAL    2'h1
`define CSP_MODE_SLAVE    2'h0
`define CSP_RESP_OKAY     2'h0
`define CSP_RESP_SLVERR   2'h2
`endif

// ===== csp_pkg.sv
// types shared by the clocked serial port modules
// assumes nothing beyond a SystemVerilog compiler
package csp_pkg;
    // shift engine states, one-hot
    typedef enum logic [2:0] {
        CSP_IDLE  = 3'h1,
        CSP_LOW   = 3'h2,
        CSP_HIGH  = 3'h4
    } csp_state_t;
endpackage : csp_pkg

// ===== csp_ctl_if.sv
// control bundle between register file and shift engine
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface csp_ctl_if;
    logic       start;     // one-cycle trigger pulse
    logic       reinit;    // data register access pulse
    logic       lsb_first; // bit order
    logic [1:0] mode;      // clock mode
    logic       tick;      // master half-period enable
    logic [7:0] load_byte; // byte to send
    logic       running;   // engine busy
    logic       done;      // one-cycle end pulse
    logic [7:0] shreg;     // shift register contents
    modport regs (output start, reinit, lsb_first, mode, load_byte,
                  input running, done, shreg);
    modport eng  (input start, reinit, lsb_first, mode, tick, load_byte,
                  output running, done, shreg);
    modport gen  (input mode, output tick);
endinterface : csp_ctl_if

// ===== csp_tick_gen.sv
// master shift clock rate: half-period enable pulses
// assumes timer overflow already synchronised to core_clk
`timescale 1ns/100ps
`include "csp_consts.svh"
module csp_tick_gen
    import csp_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // timer overflow level, toggles each reload
    input  wire logic ovf_sync,
    // control bundle
    csp_ctl_if.gen    ctl
);
    logic div_q;  // cpu clock halving
    logic ovf_q;  // last overflow level

    // divider and overflow edge memory
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            div_q <= ~div_q;
            ovf_q <= ovf_sync;
        end
    end

    // one half-period per tick; overflow edges give reload*2 period
    always_comb begin
        unique case (ctl.mode)
            `CSP_MODE_CLK:   ctl.tick = 1'b1;
            `CSP_MODE_CLK2:  ctl.tick = div_q;
            `CSP_MODE_TIMER_OVERFLOW_SIGNAL: ctl.tick = ovf_sync ^ ovf_q;
            default:         ctl.tick = 1'b0;
        endcase
    end
endmodule : csp_tick_gen

// ===== csp_top.sv
// clocked serial port, eight bit, with axi4-lite register access
// assumes pins and timer overflow arrive asynchronous to core_clk
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "csp_consts.svh"
module csp_top
    import csp_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // port-2 pins, three signals each
    input  wire logic [3:0]  p2_in,
    output logic [3:0]       p2_out,
    output logic [3:0]       p2_oe,
    output logic             port2_pullup_enable,
    // general i/o side of port 2
    input  wire logic [3:0]  gpio_out,
    input  wire logic [3:0]  gpio_oe,
    output logic [3:0]       gpio_in,
    // timer overflow level and interrupt request
    input  wire logic        timer_overflow_signal,
    output logic             serial_irq
);
    csp_ctl_if ctl ();

    // registers
    logic       port_function_select_q;
    logic       bit_order_select_q;
    logic [1:0] clock_mode_q;
    logic       serial_irq_enable_q;
    logic       pullup_q;
    logic       serial_irq_flag_bit_q;
    // synchronisers: first stage read only by second
    logic [3:0] pin_s1_q, pin_s2_q;
    logic       ovf_s1_q, ovf_s2_q;
    // shift engine
    csp_state_t st_q;
    logic [7:0] shreg_q;
    logic [3:0] cnt_q;
    logic       sclk_q;     // active-low shift clock, high at rest
    logic       serial_data_out_q;
    logic       sclk_in_q;  // previous synced external clock
    logic       done_q;
    logic [7:0] tx_q;       // byte sent, apart from receive
    logic [2:0] samp_q;     // rise strobes, pin lag
    // axi handshake state
    logic        aw_held_q, w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_go, rd_go;
    logic [7:0]  wr_idx, rd_idx;
    logic [3:0]  rd_val;
    logic        rd_ok, wr_ok;

    csp_tick_gen u_tick (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ovf_sync (ovf_s2_q),
        .ctl      (ctl.gen)
    );

    // two-stage synchronisers for pins and timer overflow
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            ovf_s1_q <= 1'b0;
            ovf_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= p2_in;
            pin_s2_q <= pin_s1_q;
            ovf_s1_q <= timer_overflow_signal;
            ovf_s2_q <= ovf_s1_q;
        end
    end

    // ---- axi4-lite write path ----
    assign wr_go  = (aw_held_q || s_axi_awvalid) &&
                    (w_held_q || s_axi_wvalid) && !s_axi_bvalid;
    assign wr_idx = aw_held_q ? awaddr_q[9:2] : s_axi_awaddr[9:2];
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        wr_lane;
    assign wd = w_held_q ? wdata_q : s_axi_wdata;
    assign ws = w_held_q ? wstrb_q : s_axi_wstrb;
    assign wr_lane = wr_go && ws[0];  // registers live in lane 0
    assign wr_ok = (wr_idx == `CSP_IDX_IRQ_FLAG) ||
                   (wr_idx == `CSP_IDX_IRQ_MASK) ||
                   (wr_idx == `CSP_IDX_PULLUP) ||
                   (wr_idx == `CSP_IDX_CONFIG) ||
                   (wr_idx == `CSP_IDX_RUN) ||
                   (wr_idx == `CSP_IDX_DATA_LO) ||
                   (wr_idx == `CSP_IDX_DATA_HI);

    // address and data accepted in either order, held till both
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CSP_RESP_OKAY;
        end else if (wr_go) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_ok ? `CSP_RESP_OKAY : `CSP_RESP_SLVERR;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ---- axi4-lite read path ----
    assign rd_go  = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[9:2];
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 4'h0;
        unique case (rd_idx)
            `CSP_IDX_IRQ_FLAG: rd_val = {3'h0, serial_irq_flag_bit_q};
            `CSP_IDX_IRQ_MASK: rd_val = {2'h0, serial_irq_enable_q, 1'b0};
            `CSP_IDX_PULLUP:   rd_val = {1'b0, pullup_q, 2'h0};
            `CSP_IDX_CONFIG:   rd_val = {port_function_select_q,
                                         bit_order_select_q, clock_mode_q};
            `CSP_IDX_RUN:      rd_val = {2'h0, ctl.running, 1'b0};
            `CSP_IDX_DATA_LO:  rd_val = shreg_q[3:0];
            `CSP_IDX_DATA_HI:  rd_val = shreg_q[7:4];
            default:           rd_ok  = 1'b0;
        endcase
    end

    // one read at a time; answer the edge after the address
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CSP_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {28'h0000000, rd_val};
            s_axi_rresp   <= rd_ok ? `CSP_RESP_OKAY : `CSP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ---- software registers ----
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port_function_select_q <= 1'b0;
            bit_order_select_q     <= 1'b0;
            clock_mode_q           <= `CSP_MODE_SLAVE;
            serial_irq_enable_q    <= 1'b0;
            pullup_q               <= 1'b0;
        end else if (wr_lane) begin
            if (wr_idx == `CSP_IDX_CONFIG) begin
                port_function_select_q <= wd[`CSP_BIT_PFS];
                bit_order_select_q     <= wd[`CSP_BIT_ORDER];
                clock_mode_q           <= wd[1:0];
            end
            if (wr_idx == `CSP_IDX_IRQ_MASK)
                serial_irq_enable_q <= wd[`CSP_BIT_MASK_SIO];
            if (wr_idx == `CSP_IDX_PULLUP)
                pullup_q <= wd[`CSP_BIT_PORT2_PULLUP_ENABLE];
        end
    end

    // bundle fields towards the engine
    assign ctl.lsb_first = bit_order_select_q;
    assign ctl.mode      = clock_mode_q;
    // trigger ignored while running: given once per run
    assign ctl.start = wr_lane && (wr_idx == `CSP_IDX_RUN) &&
                       wd[`CSP_BIT_TRIG] && !ctl.running;
    // any data register read, or data register write with lane 0 strobed, while idle raises reinit, which the shift engine never reads
    assign ctl.reinit = !ctl.running &&
        ((wr_lane && (wr_idx == `CSP_IDX_DATA_LO ||
                      wr_idx == `CSP_IDX_DATA_HI)) ||
         (rd_go && (rd_idx == `CSP_IDX_DATA_LO ||
                    rd_idx == `CSP_IDX_DATA_HI)));
    assign ctl.load_byte = shreg_q;
    assign ctl.running   = (st_q != CSP_IDLE);
    assign ctl.done      = done_q;
    assign ctl.shreg     = shreg_q;

    // interrupt flag: set wins over clear-on-read
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            serial_irq_flag_bit_q <= 1'b0;
        else if (done_q)
            serial_irq_flag_bit_q <= 1'b1;
        else if (rd_go && rd_idx == `CSP_IDX_IRQ_FLAG)
            serial_irq_flag_bit_q <= 1'b0;
    end

    // ---- shift engine ----
    logic ext_rise, ext_fall, step_fall, step_rise, master;
    assign master    = (clock_mode_q != `CSP_MODE_SLAVE);
    assign ext_rise  = pin_s2_q[2] && !sclk_in_q;
    assign ext_fall  = !pin_s2_q[2] && sclk_in_q;
    assign step_fall = master ? ctl.tick : ext_fall;
    assign step_rise = master ? ctl.tick : ext_rise;

    // external clock edge memory
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            sclk_in_q <= 1'b1;
        else
            sclk_in_q <= pin_s2_q[2];
    end

    // state, counter, shift clock and data shifting
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q   <= CSP_IDLE;
            cnt_q  <= 4'h0;
            sclk_q <= 1'b1;
            serial_data_out_q <= 1'b1;
            done_q <= 1'b0;
            samp_q <= 3'h0;
        end else begin
            done_q <= 1'b0;
            // own clock reaches the synced pin three cycles late
            samp_q <= {samp_q[1:0], st_q == CSP_LOW && step_rise};
            unique case (st_q)
                CSP_IDLE: begin
                    sclk_q <= 1'b1;
                    if (ctl.start) begin
                        st_q  <= CSP_HIGH;
                        tx_q  <= shreg_q;
                        cnt_q <= 4'h0;
                    end
                end
                CSP_HIGH: begin
                    // falling edge: present next bit
                    if (step_fall) begin
                        sclk_q <= 1'b0;
                        serial_data_out_q <= bit_order_select_q ?
                            tx_q[cnt_q[2:0]] : tx_q[~cnt_q[2:0]];
                        st_q   <= CSP_LOW;
                    end
                end
                CSP_LOW: begin
                    // rising edge: sample and count
                    if (step_rise) begin
                        sclk_q <= 1'b1;
                        cnt_q  <= cnt_q + 4'h1;
                        if (cnt_q == `CSP_BITS - 4'h1) begin
                            st_q   <= CSP_IDLE;
                            done_q <= 1'b1;
                        end else
                            st_q <= CSP_HIGH;
                    end
                end
                default: st_q <= CSP_IDLE;
            endcase
        end
    end

    // shift register: software nibbles when idle, bits on each rise, three cycles late in master modes
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            shreg_q <= {`CSP_NIB_RESET, `CSP_NIB_RESET};
        else if (master ? samp_q[2] : st_q == CSP_LOW && step_rise) begin
            if (bit_order_select_q)
                shreg_q <= {pin_s2_q[0], shreg_q[7:1]};
            else
                shreg_q <= {shreg_q[6:0], pin_s2_q[0]};
        end else if (wr_lane && !ctl.running) begin
            if (wr_idx == `CSP_IDX_DATA_LO)
                shreg_q[3:0] <= wd[3:0];
            if (wr_idx == `CSP_IDX_DATA_HI)
                shreg_q[7:4] <= wd[3:0];
        end
    end

    // pin muxing, registered outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            p2_out              <= 4'h0;
            p2_oe               <= 4'h0;
            gpio_in             <= 4'h0;
            port2_pullup_enable <= 1'b0;
            serial_irq          <= 1'b0;
        end else begin
            port2_pullup_enable <= pullup_q;
            serial_irq <= serial_irq_flag_bit_q && serial_irq_enable_q;
            gpio_in    <= pin_s2_q;
            if (port_function_select_q) begin
                // pin 0 in, pin 1 out, pin 2 clock, pin 3 unused
                p2_out <= {1'b0, sclk_q, serial_data_out_q, 1'b0};
                p2_oe  <= {1'b0, master, 1'b1, 1'b0};
            end else begin
                p2_out <= gpio_out;
                p2_oe  <= gpio_oe;
            end
        end
    end
endmodule : csp_top

// ===== csp_top_sva.sv
// checker for the clocked serial port, watching top-level ports only
// assumes one clock domain and the offsets of the shared constants header
`timescale 1ns/100ps
`include "csp_consts.svh"
module csp_top_sva
    import csp_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // pins and request
    input wire logic [3:0]  p2_out,
    input wire logic [3:0]  p2_oe,
    input wire logic        serial_irq
);
    logic [11:0] ar_q;    // address of the read in flight
    logic [11:0] aw_q;    // address of the last write
    logic [3:0]  wd_q;    // data of the last write
    logic        bv_q;    // response valid, one cycle late
    logic        mask_q;  // shadow of the irq enable bit
    logic        sc_q;    // clock pin, one cycle late
    logic [3:0]  falls_q; // clock falls since the last write

    // capture bus addresses and data as they are taken
    always_ff @(posedge core_clk) begin
        if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[3:0];
    end

    // mask shadow follows completed writes; late by one cycle on purpose
    always_ff @(posedge core_clk) begin
        bv_q <= s_axi_bvalid;
        if (!rst_n) mask_q <= 1'b0;
        else if (s_axi_bvalid && !bv_q && aw_q[9:2] == `CSP_IDX_IRQ_MASK)
            mask_q <= wd_q[`CSP_BIT_MASK_SIO];
    end

    // count driven clock falls; any write, the trigger too, restarts it
    always_ff @(posedge core_clk) begin
        sc_q <= p2_out[2];
        if (!rst_n || (s_axi_bvalid && !bv_q)) falls_q <= 4'h0;
        else if (p2_oe[2] && sc_q && !p2_out[2]) falls_q <= falls_q + 4'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    pulse_count_a: assert property (falls_q <= 4'h8)
        else $error("more than eight shift clock pulses");
    serial_data_out_fall_a: assert property (p2_oe[2] && falls_q != 4'h0 &&
        $changed(p2_out[1]) |-> !p2_out[2])
        else $error("data out changed while clock high");
    sclk_oe_a: assert property (p2_oe[2] |-> p2_oe[1] && !p2_oe[3])
        else $error("clock driven without data out");
    irq_mask_a: assert property (serial_irq |-> mask_q ||
        (s_axi_bvalid && !bv_q))
        else $error("interrupt raised while masked");
    flag_upper_a: assert property (s_axi_rvalid &&
        ar_q[9:2] == `CSP_IDX_IRQ_FLAG |-> s_axi_rdata[31:1] == 31'h0)
        else $error("flag register upper bits not zero");
    run_read_a: assert property (s_axi_rvalid &&
        ar_q[9:2] == `CSP_IDX_RUN |-> !s_axi_rdata[0] &&
        s_axi_rdata[31:2] == 30'h0)
        else $error("trigger or unused bits read nonzero");
    unmapped_a: assert property (s_axi_rvalid && !(ar_q[9:2] inside
        {`CSP_IDX_IRQ_FLAG, `CSP_IDX_IRQ_MASK, `CSP_IDX_PULLUP,
        `CSP_IDX_CONFIG, `CSP_IDX_RUN, `CSP_IDX_DATA_LO,
        `CSP_IDX_DATA_HI}) |-> s_axi_rresp == `CSP_RESP_SLVERR &&
        s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted during read data");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid ##1 !s_axi_awready
        || s_axi_awready)
        else $error("write response late");

    cover property ($rose(serial_irq));
    cover property (falls_q == 4'h8);
    cover property (s_axi_rvalid && s_axi_rresp == `CSP_RESP_SLVERR);
endmodule : csp_top_sva

bind csp_top csp_top_sva u_sva (.core_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .p2_out, .p2_oe, .serial_irq);

// ===== csp_peer.sv
// external serial device: slave to a master port, master to a slave one
// assumes the bench resolves the clock pin and pulses arm before a frame
`timescale 1ns/100ps
module csp_peer
    import csp_pkg::*;
(
    // bench side
    input  wire logic       core_clk,
    input  wire logic       arm,
    input  wire logic       go,
    input  wire logic       lsb_first,
    input  wire logic [7:0] ptx,
    output logic            busy,
    output logic [7:0]      rx,
    // serial pins
    input  wire logic       clk_pin,
    input  wire logic       serial_data_out,
    output logic            serial_data_in,
    output logic            sclk_drv
);
    logic [3:0] bits  = 4'h0;  // bits exchanged this frame
    logic [4:0] edges = 5'h0;  // clock edges still to make
    logic [2:0] hcnt  = 3'h0;  // cycles into half period

    assign busy = (edges != 5'h0);
    initial sclk_drv = 1'b1;
    initial serial_data_in = 1'b0;

    // ten pulses, only after go, i.e. after trigger; idle high
    always @(posedge core_clk) begin
        if (go) edges <= 5'h14;
        else if (busy && hcnt == 3'h5) begin
            sclk_drv <= ~sclk_drv;
            edges <= edges - 5'h1;
        end
        hcnt <= (go || hcnt == 3'h5) ? 3'h0 : hcnt + 3'h1;
    end

    // eight bits in on rising clock
    always @(posedge clk_pin or posedge arm) begin
        if (arm) bits <= 4'h0;
        else if (bits < 4'h8) begin
            rx <= {rx[6:0], serial_data_out};
            bits <= bits + 4'h1;
        end
    end

    // next bit on falling clock; past the frame the line keeps changing
    always @(negedge clk_pin) begin
        if (bits >= 4'h8) serial_data_in <= ~serial_data_in;
        else serial_data_in <= lsb_first ? ptx[bits[2:0]] : ptx[3'h7 - bits[2:0]];
    end
endmodule : csp_peer

// ===== testbench.sv
// self-checking bench for the clocked serial port
// assumes design, checker and peer model are compiled before it
`timescale 1ns/100ps
`include "csp_consts.svh"
module testbench
    import csp_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'h1, gpio_out = 4'h9, gpio_oe = 4'h3;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, timer_overflow_signal = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, port2_pullup_enable;
    logic        serial_irq, clk_pin, serial_data_in, sclk_drv, busy;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, tdiv = 2'h0;
    logic [3:0]  p2_in, p2_out, p2_oe, gpio_in;
    logic        arm = 1'b0, go = 1'b0, lsb = 1'b0;
    logic [7:0]  ptx = 8'h00, rx;
    logic [20:0] row;  // config, mask, byte sent, byte received
    int          fail_count = 0, num_checks = 0, i, k;
    // modes 3, 2, 1 master, then slave; timer row masked
    localparam logic [20:0] ROWS [4] = '{{4'hB, 1'b1, 8'hA5, 8'h3C},
        {4'hE, 1'b1, 8'h81, 8'h7E}, {4'h9, 1'b0, 8'h12, 8'hC3},
        {4'hC, 1'b1, 8'h5A, 8'h96}};
    localparam logic [11:0] RST_A [4] = '{`CSP_OFF_CONFIG,
        `CSP_OFF_IRQ_MASK, `CSP_OFF_PULLUP, `CSP_OFF_RUN};

    // undriven pins sit at pull-up level
    assign clk_pin = p2_oe[2] ? p2_out[2] : sclk_drv;
    assign p2_in = {p2_oe[3] ? p2_out[3] : 1'b1, clk_pin,
                    p2_oe[1] ? p2_out[1] : 1'b1, p2_oe[0] ? p2_out[0] : serial_data_in};

    initial forever #2.5 core_clk = ~core_clk;
    // timer overflow level toggles every four cycles
    always @(posedge core_clk) begin
        tdiv <= tdiv + 2'h1;
        if (tdiv == 2'h3) timer_overflow_signal <= ~timer_overflow_signal;
    end

    csp_top u_dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .p2_in, .p2_out,
        .p2_oe, .port2_pullup_enable, .gpio_out, .gpio_oe, .gpio_in,
        .timer_overflow_signal, .serial_irq);
    csp_peer u_peer (.core_clk, .arm, .go, .lsb_first(lsb), .ptx, .busy,
        .rx, .clk_pin, .serial_data_out(p2_in[1]), .serial_data_in, .sclk_drv);

    task automatic finish_test;
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // wait ran out
    task automatic tmo;
        chk(32'h0, 32'h1);
        finish_test();
    endtask : tmo

    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int j = 0; j < 8; j++) rev[j] = v[7 - j];
    endfunction : rev

    // one write, aw and w together
    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {28'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) tmo();
    endtask : wr

    // one read into rv and rs
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) tmo();
    endtask : rd

    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd(RST_A[i]);
            chk(rv, 32'h0);
        end
        chk({24'h0, p2_oe, p2_out}, 32'h39);
        chk({28'h0, gpio_in}, 32'hD);
        wr(`CSP_OFF_PULLUP, 4'h4);
        @(posedge core_clk);
        chk({31'h0, port2_pullup_enable}, 32'h1);
        for (i = 0; i < 4; i++) begin
            row = ROWS[i];
            lsb <= row[19];
            ptx <= row[7:0];
            arm <= 1'b1;
            wr(`CSP_OFF_DATA_LO, row[11:8]);
            arm <= 1'b0;
            wr(`CSP_OFF_DATA_HI, row[15:12]);
            wr(`CSP_OFF_CONFIG, row[20:17]);
            wr(`CSP_OFF_IRQ_MASK, {2'h0, row[16], 1'b0});
            rd(`CSP_OFF_IRQ_FLAG);
            wr(`CSP_OFF_RUN, 4'h1);
            if (row[18:17] == `CSP_MODE_SLAVE) begin
                go <= 1'b1;
                @(posedge core_clk);
                go <= 1'b0;
            end
            rd(`CSP_OFF_RUN);
            chk(rv, 32'h2);
            for (k = 0; k < 400 && (rv[1] !== 1'b0 || busy); k++)
                rd(`CSP_OFF_RUN);
            if (k == 400) tmo();
            chk({31'h0, serial_irq}, {31'h0, row[16]});
            chk({24'h0, rx}, {24'h0, row[19] ? rev(row[15:8]) : row[15:8]});
            rd(`CSP_OFF_DATA_LO);
            chk(rv, {28'h0, row[3:0]});
            rd(`CSP_OFF_DATA_HI);
            chk(rv, {28'h0, row[7:4]});
            rd(`CSP_OFF_IRQ_FLAG);
            chk(rv, 32'h1);
            rd(`CSP_OFF_IRQ_FLAG);
            chk(rv, 32'h0);
        end
        rd(`CSP_OFF_CONFIG);
        chk(rv, 32'hC);
        rd(12'h3FC);
        chk({30'h0, rs}, {30'h0, `CSP_RESP_SLVERR});
        finish_test();
    end
endmodule : testbench
